// *** apd_defs.svh ***
// register indexes, field positions, write masks and reset values of the diagnostic bank
`ifndef APD_DEFS_SVH
`define APD_DEFS_SVH

// register indexes; the byte address on the bus is four times the index
`define APD_IDX_AFE_REF     9'h134
`define APD_IDX_ADC_BIAS    9'h135
`define APD_IDX_FILT_BIAS   9'h136
`define APD_IDX_RSVD        9'h137
`define APD_IDX_TEST_ROUTE  9'h13C
`define APD_IDX_TUNE_OVR    9'h13D
`define APD_IDX_TUNE_STAT   9'h13E
`define APD_IDX_FLAG_POL    9'h13F
`define APD_IDX_PUMP        9'h140
`define APD_IDX_PLL_CTRL    9'h141

// word index bits of haddr and the bits above, which must be zero
`define APD_ADDR_IDX        10:2
`define APD_ADDR_HI         31:11

// htrans encoding bit that marks an active transfer (NONSEQ or SEQ)
`define APD_HTRANS_ACTIVE   1

// writable bits of each register
`define APD_WM_AFE_REF      8'h0F
`define APD_WM_ADC_BIAS     8'h7F
`define APD_WM_FILT_BIAS    8'h0F
`define APD_WM_TEST_ROUTE   8'h0F
`define APD_WM_TUNE_OVR     8'h9F
`define APD_WM_FLAG_POL     8'h03
`define APD_WM_PUMP         8'h3F
`define APD_WM_PLL_CTRL     8'h0F

// reset values
`define APD_RST_AFE_REF     8'h02
`define APD_RST_ADC_BIAS    8'h18
`define APD_RST_FILT_BIAS   8'h05
`define APD_RST_TEST_ROUTE  8'h00
`define APD_RST_TUNE_OVR    8'h00
`define APD_RST_FLAG_POL    8'h00
`define APD_RST_PUMP        8'h04
`define APD_RST_PLL_CTRL    8'h00
`define APD_RST_TUNE_CODE   5'h00

// field positions
`define APD_F_REF_LOW       3
`define APD_F_REG_SEL       2:1
`define APD_F_CLK_MULT      0
`define APD_F_REFBUF_BIAS   6:5
`define APD_F_CMP_CUR       4:3
`define APD_F_REF_LEVEL     2
`define APD_F_ADC_BIAS      1:0
`define APD_F_FILT_MULT     3:2
`define APD_F_CONV_MULT     1:0
`define APD_F_TEST_ROUTE    3
`define APD_F_FILT_DIS      2
`define APD_F_SRC_SEL       1
`define APD_F_TUNE_RST      0
`define APD_F_TUNE_FORCE    7
`define APD_F_TUNE_IN       4:0
`define APD_F_AUD_INV       1
`define APD_F_VID_INV       0
`define APD_F_PUMP          5:0
`define APD_F_AUX_RST       3
`define APD_F_VID_RST       2
`define APD_F_AUX_FRAC      1
`define APD_F_VID_FRAC      0

// tuning code top bit index and the successive approximation seed
`define APD_TUNE_MSB        4
`define APD_TUNE_SEED       5'h10

`endif

// *** apd_pkg.sv ***
// shared types of the diagnostic bank
package apd_pkg;

  typedef enum logic [1:0] {
    APD_TUNE_HOLD,
    APD_TUNE_SEARCH,
    APD_TUNE_DONE
  } apd_tune_state_e;

  typedef logic [7:0] apd_byte_t;

endpackage : apd_pkg

// *** apd_tune_if.sv ***
// link between the register bank and the filter tuning engine
`timescale 1ns/10ps
interface apd_tune_if;
  logic       hold;
  logic       compare;
  logic [4:0] code;
  logic       ready;

  modport bank   (output hold, output compare, input code, input ready);
  modport engine (input hold, input compare, output code, output ready);
endinterface : apd_tune_if

// *** apd_tuner.sv ***
// filter auto-tuning engine: five-step successive approximation of the tuning code
`timescale 1ns/10ps
`include "apd_defs.svh"
module apd_tuner (
  input  wire logic core_clk,
  input  wire logic reset,
  apd_tune_if.engine tif
);

  apd_pkg::apd_tune_state_e state_r;
  logic [4:0]               code_r;
  logic [2:0]               step_r;
  logic                     ready_r;

  // compare high means the trial code is still too low, so the trial bit stays set
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_r <= apd_pkg::APD_TUNE_HOLD;
      code_r  <= `APD_RST_TUNE_CODE;
      step_r  <= 3'h0;
      ready_r <= 1'b0;
    end else if (tif.hold) begin
      // held in reset while the control bit is set; ready drops at once
      state_r <= apd_pkg::APD_TUNE_HOLD;
      code_r  <= `APD_RST_TUNE_CODE;
      step_r  <= 3'h0;
      ready_r <= 1'b0;
    end else begin
      case (state_r)
        apd_pkg::APD_TUNE_HOLD: begin
          // restart after release: seed the top bit
          state_r <= apd_pkg::APD_TUNE_SEARCH;
          code_r  <= `APD_TUNE_SEED;
          step_r  <= 3'(`APD_TUNE_MSB);
        end
        apd_pkg::APD_TUNE_SEARCH: begin
          if (!tif.compare) begin
            code_r[step_r] <= 1'b0;
          end
          if (step_r == 3'h0) begin
            state_r <= apd_pkg::APD_TUNE_DONE;
            ready_r <= 1'b1;
          end else begin
            code_r[step_r - 3'h1] <= 1'b1;
            step_r                <= step_r - 3'h1;
          end
        end
        apd_pkg::APD_TUNE_DONE: begin
          state_r <= apd_pkg::APD_TUNE_DONE;
        end
        default: begin
          state_r <= apd_pkg::APD_TUNE_HOLD;
        end
      endcase
    end
  end

  assign tif.code  = code_r;
  assign tif.ready = ready_r;

endmodule : apd_tuner

// *** apd_diag_bank.sv ***
// analog front end and PLL diagnostic control bank behind an AHB-Lite slave
// Notes on behaviour
// - one bit picks the ADC reference, 0 for 1.60 V, 1 for 1.20 V.
// - two-bit core regulator target 1.20 to 1.38 V, reset value 01.
// - clock select bit picks DLL 5x output at 0, 4x output at 1.
// - buffer bias field bits 6:5 resets 00; comparator field bits 4:3 resets 11.
// - one bit selects reference levels 1.6/0.8 V or 1.5/0.9 V.
// - two-bit ADC bias current field, reset value 00.
// - two-bit filter bias multiplier field, reset value 01.
// - two-bit converter bias multiplier field, reset value 01.
// - test route bit at 1 connects first ADC input to two pins.
// - filter disable bit at 1 disables channel one filter in test mode.
// - source select feeds ADC from filter at 0, first gain stage at 1.
// - tuning reset bit holds tuning logic; release restarts auto-tuning.
// - override bit applies software tuning code instead of auto-tuned code.
// - read-only ready bit is 1 once auto-tuning has completed.
// - read-only field shows the code chosen by auto-tuning.
// - two bits invert the dual flag sent to audio and video decoders.
// - six-bit charge pump code, reset value 0x04.
// - video and auxiliary unlock flags set on detected unlock, zero after reset.
// - bits 5 and 4 show live video and auxiliary PLL lock state.
// - bit 3 holds auxiliary PLL reset, bit 2 video PLL reset.
// - bits 1 and 0 disable fractional division, auxiliary and video.
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/10ps
`include "apd_defs.svh"
module apd_diag_bank (
  input  wire logic        core_clk,
  input  wire logic        reset,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // analog and decoder side inputs
  input  wire logic        dual_flag_in,
  input  wire logic        tune_compare,
  input  wire logic        video_pll_lock_in,
  input  wire logic        aux_pll_lock_in,
  // analog controls
  output logic             adc_ref_low_select,
  output logic [1:0]       core_regulator_select,
  output logic             adc_clock_multiple_select,
  output logic [1:0]       ref_buffer_bias,
  output logic [1:0]       comparator_current,
  output logic             ref_level_select,
  output logic [1:0]       adc_bias_current,
  output logic [1:0]       filter_bias_multiplier,
  output logic [1:0]       converter_bias_multiplier,
  output logic             chan_one_test_route,
  output logic             chan_one_filter_disable,
  output logic             first_adc_source_select,
  output logic [4:0]       filter_tune_code,
  // decoder flags
  output logic             audio_dual_flag,
  output logic             video_dual_flag,
  // PLL controls
  output logic [5:0]       pll_pump_code,
  output logic             aux_pll_reset,
  output logic             video_pll_reset,
  output logic             aux_pll_fraction_disable,
  output logic             video_pll_fraction_disable
);

  // software-visible storage
  apd_pkg::apd_byte_t afe_ref_r;
  apd_pkg::apd_byte_t adc_bias_r;
  apd_pkg::apd_byte_t filt_bias_r;
  apd_pkg::apd_byte_t test_route_r;
  apd_pkg::apd_byte_t tune_ovr_r;
  apd_pkg::apd_byte_t flag_pol_r;
  apd_pkg::apd_byte_t pump_r;
  apd_pkg::apd_byte_t pll_ctrl_r;

  // bus pipeline state
  logic               wr_pend_r;
  logic               rd_pend_r;
  logic               mapped_r;
  logic [8:0]         idx_r;
  logic               ready_r;
  logic [31:0]        rdata_r;
  logic               resp_r;

  // status state
  logic               vid_lock_r;
  logic               aux_lock_r;
  logic               vid_lost_flag_r;
  logic               aux_lost_flag_r;
  logic [4:0]         tune_code_r;
  logic               aud_flag_r;
  logic               vid_flag_r;

  // combinational helpers
  logic               addr_take;
  logic               addr_mapped;
  logic [8:0]         addr_idx;
  logic               wr_do;
  logic               rd_do;
  apd_pkg::apd_byte_t wbyte;
  apd_pkg::apd_byte_t rd_byte;
  logic               vid_unlock_evt;
  logic               aux_unlock_evt;
  logic               status_clr;

  apd_tune_if tif ();

  apd_tuner u_tuner (
    .core_clk (core_clk),
    .reset    (reset),
    .tif      (tif)
  );

  // ---------------------------------------------------------------- bus decode
  assign addr_take = hsel & hready & htrans[`APD_HTRANS_ACTIVE];
  assign addr_idx  = haddr[`APD_ADDR_IDX];

  always_comb begin
    addr_mapped = 1'b0;
    if (haddr[`APD_ADDR_HI] == '0) begin
      case (addr_idx)
        `APD_IDX_AFE_REF,
        `APD_IDX_ADC_BIAS,
        `APD_IDX_FILT_BIAS,
        `APD_IDX_RSVD,
        `APD_IDX_TEST_ROUTE,
        `APD_IDX_TUNE_OVR,
        `APD_IDX_TUNE_STAT,
        `APD_IDX_FLAG_POL,
        `APD_IDX_PUMP,
        `APD_IDX_PLL_CTRL: addr_mapped = 1'b1;
        default:           addr_mapped = 1'b0;
      endcase
    end
  end

  // writes finish in the data phase with no wait; reads take one wait state so the
  // returned byte always reflects a write that just completed before it
  assign wr_do = wr_pend_r & mapped_r;
  assign rd_do = rd_pend_r;
  assign wbyte = hwdata[7:0];

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      mapped_r  <= 1'b0;
      idx_r     <= '0;
    end else begin
      if (addr_take) begin
        wr_pend_r <= hwrite;
        rd_pend_r <= ~hwrite;
        mapped_r  <= addr_mapped;
        idx_r     <= addr_idx;
      end else if (hready) begin
        wr_pend_r <= 1'b0;
        rd_pend_r <= 1'b0;
      end else begin
        wr_pend_r <= wr_pend_r;
        rd_pend_r <= 1'b0;
      end
    end
  end

  // hreadyout drops for the one cycle after a read address is taken
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ready_r <= 1'b1;
    end else if (addr_take & ~hwrite) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= 1'b1;
    end
  end

  // every transfer answers OKAY, unmapped ones included
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      resp_r <= 1'b0;
    end else begin
      resp_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------- control registers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      afe_ref_r <= `APD_RST_AFE_REF;
    end else if (wr_do && idx_r == `APD_IDX_AFE_REF) begin
      afe_ref_r <= wbyte & `APD_WM_AFE_REF;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      adc_bias_r <= `APD_RST_ADC_BIAS;
    end else if (wr_do && idx_r == `APD_IDX_ADC_BIAS) begin
      adc_bias_r <= wbyte & `APD_WM_ADC_BIAS;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      filt_bias_r <= `APD_RST_FILT_BIAS;
    end else if (wr_do && idx_r == `APD_IDX_FILT_BIAS) begin
      filt_bias_r <= wbyte & `APD_WM_FILT_BIAS;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      test_route_r <= `APD_RST_TEST_ROUTE;
    end else if (wr_do && idx_r == `APD_IDX_TEST_ROUTE) begin
      test_route_r <= wbyte & `APD_WM_TEST_ROUTE;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tune_ovr_r <= `APD_RST_TUNE_OVR;
    end else if (wr_do && idx_r == `APD_IDX_TUNE_OVR) begin
      tune_ovr_r <= wbyte & `APD_WM_TUNE_OVR;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      flag_pol_r <= `APD_RST_FLAG_POL;
    end else if (wr_do && idx_r == `APD_IDX_FLAG_POL) begin
      flag_pol_r <= wbyte & `APD_WM_FLAG_POL;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pump_r <= `APD_RST_PUMP;
    end else if (wr_do && idx_r == `APD_IDX_PUMP) begin
      pump_r <= wbyte & `APD_WM_PUMP;
    end
  end

  // only the reset and fraction bits are writable; status bits above them ignore writes
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pll_ctrl_r <= `APD_RST_PLL_CTRL;
    end else if (wr_do && idx_r == `APD_IDX_PLL_CTRL) begin
      pll_ctrl_r <= wbyte & `APD_WM_PLL_CTRL;
    end
  end

  // ---------------------------------------------------------------- tuning path
  assign tif.hold    = test_route_r[`APD_F_TUNE_RST];
  assign tif.compare = tune_compare;

  // applied code is registered so the analog side never sees a mux glitch
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tune_code_r <= `APD_RST_TUNE_CODE;
    end else if (tune_ovr_r[`APD_F_TUNE_FORCE]) begin
      tune_code_r <= tune_ovr_r[`APD_F_TUNE_IN];
    end else begin
      tune_code_r <= tif.code;
    end
  end

  // ---------------------------------------------------------------- PLL lock status
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      vid_lock_r <= 1'b0;
      aux_lock_r <= 1'b0;
    end else begin
      vid_lock_r <= video_pll_lock_in;
      aux_lock_r <= aux_pll_lock_in;
    end
  end

  // an unlock is a fall of the lock level; the flag sticks until software reads it
  assign vid_unlock_evt = vid_lock_r & ~video_pll_lock_in;
  assign aux_unlock_evt = aux_lock_r & ~aux_pll_lock_in;
  assign status_clr     = rd_do && mapped_r && idx_r == `APD_IDX_PLL_CTRL;

  // a new unlock in the cycle of the clearing read wins, so no event is lost
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      vid_lost_flag_r <= 1'b0;
      aux_lost_flag_r <= 1'b0;
    end else begin
      vid_lost_flag_r <= vid_unlock_evt | (vid_lost_flag_r & ~status_clr);
      aux_lost_flag_r <= aux_unlock_evt | (aux_lost_flag_r & ~status_clr);
    end
  end

  // ---------------------------------------------------------------- dual flags
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      aud_flag_r <= 1'b0;
      vid_flag_r <= 1'b0;
    end else begin
      aud_flag_r <= dual_flag_in ^ flag_pol_r[`APD_F_AUD_INV];
      vid_flag_r <= dual_flag_in ^ flag_pol_r[`APD_F_VID_INV];
    end
  end

  // ---------------------------------------------------------------- read path
  always_comb begin
    rd_byte = '0;
    case (idx_r)
      `APD_IDX_AFE_REF:    rd_byte = afe_ref_r;
      `APD_IDX_ADC_BIAS:   rd_byte = adc_bias_r;
      `APD_IDX_FILT_BIAS:  rd_byte = filt_bias_r;
      `APD_IDX_TEST_ROUTE: rd_byte = test_route_r;
      `APD_IDX_TUNE_OVR:   rd_byte = tune_ovr_r;
      `APD_IDX_TUNE_STAT:  rd_byte = {2'b00, tif.ready, tif.code};
      `APD_IDX_FLAG_POL:   rd_byte = flag_pol_r;
      `APD_IDX_PUMP:       rd_byte = pump_r;
      `APD_IDX_PLL_CTRL: begin
        rd_byte = {vid_lost_flag_r, aux_lost_flag_r, vid_lock_r, aux_lock_r,
                   pll_ctrl_r[`APD_F_AUX_RST:`APD_F_VID_FRAC]};
      end
      default:             rd_byte = '0;
    endcase
  end

  // unmapped reads return zero
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rdata_r <= '0;
    end else if (rd_do) begin
      rdata_r <= mapped_r ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // ---------------------------------------------------------------- outputs
  assign hreadyout = ready_r;
  assign hresp     = resp_r;
  assign hrdata    = rdata_r;

  assign adc_ref_low_select        = afe_ref_r[`APD_F_REF_LOW];
  assign core_regulator_select     = afe_ref_r[`APD_F_REG_SEL];
  assign adc_clock_multiple_select = afe_ref_r[`APD_F_CLK_MULT];
  assign ref_buffer_bias           = adc_bias_r[`APD_F_REFBUF_BIAS];
  assign comparator_current        = adc_bias_r[`APD_F_CMP_CUR];
  assign ref_level_select          = adc_bias_r[`APD_F_REF_LEVEL];
  assign adc_bias_current          = adc_bias_r[`APD_F_ADC_BIAS];
  assign filter_bias_multiplier    = filt_bias_r[`APD_F_FILT_MULT];
  assign converter_bias_multiplier = filt_bias_r[`APD_F_CONV_MULT];
  assign chan_one_test_route       = test_route_r[`APD_F_TEST_ROUTE];
  assign chan_one_filter_disable   = test_route_r[`APD_F_FILT_DIS];
  assign first_adc_source_select   = test_route_r[`APD_F_SRC_SEL];
  assign filter_tune_code          = tune_code_r;
  assign audio_dual_flag           = aud_flag_r;
  assign video_dual_flag           = vid_flag_r;
  assign pll_pump_code             = pump_r[`APD_F_PUMP];
  assign aux_pll_reset             = pll_ctrl_r[`APD_F_AUX_RST];
  assign video_pll_reset           = pll_ctrl_r[`APD_F_VID_RST];
  assign aux_pll_fraction_disable  = pll_ctrl_r[`APD_F_AUX_FRAC];
  assign video_pll_fraction_disable = pll_ctrl_r[`APD_F_VID_FRAC];

endmodule : apd_diag_bank

// *** apd_diag_chk.sv ***
// port checker of the diagnostic bank
`timescale 1ns/10ps
module apd_diag_chk (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        dual_flag_in,
  input wire logic        video_pll_lock_in,
  input wire logic        aux_pll_lock_in,
  input wire logic [1:0]  core_regulator_select,
  input wire logic        audio_dual_flag,
  input wire logic        video_dual_flag,
  input wire logic [5:0]  pll_pump_code,
  input wire logic        aux_pll_reset,
  input wire logic        video_pll_reset,
  input wire logic        aux_pll_fraction_disable,
  input wire logic        video_pll_fraction_disable
);
  logic        take;
  logic        wr_dp_r;
  logic [31:0] adr_r;

  assign take = hsel & hready & htrans[1];

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_dp_r <= 1'b0;
      adr_r   <= 32'h0;
    end else begin
      wr_dp_r <= take & hwrite;
      if (take) adr_r <= haddr;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_rd; take && !hwrite; endsequence
  sequence s_rd_wait; !hreadyout ##1 hreadyout; endsequence

  property p_okay; hresp == 1'b0; endproperty
  property p_rd_wait; s_rd |=> s_rd_wait; endproperty
  property p_wr_nowait; take && hwrite |=> hreadyout; endproperty
  property p_rd_upper; s_rd |-> ##2 hrdata[31:8] == 24'h0; endproperty
  property p_rd_hole;
    s_rd ##1 (adr_r[31:11] != 21'h0 || adr_r[10:2] == 9'h137) |=> hrdata == 32'h0;
  endproperty
  // lock inputs are sampled one cycle before the read data is loaded
  property p_lock_rd;
    s_rd ##1 adr_r == 32'h504 |=> hrdata[5:4] == $past({video_pll_lock_in, aux_pll_lock_in}, 2);
  endproperty
  property p_pump_wr; wr_dp_r && adr_r == 32'h500 |=> pll_pump_code == $past(hwdata[5:0]);
  endproperty
  property p_ctrl_wr;
    wr_dp_r && adr_r == 32'h504 |=> {aux_pll_reset, video_pll_reset, aux_pll_fraction_disable,
      video_pll_fraction_disable} == $past(hwdata[3:0]);
  endproperty
  // a polarity write in flight may cancel the toggle, so those cycles are excluded
  property p_flag;
    $changed(dual_flag_in) && !$past(wr_dp_r) |=>
      $changed(audio_dual_flag) && $changed(video_dual_flag);
  endproperty
  property p_rst; $fell(reset) |-> pll_pump_code == 6'h04 && core_regulator_select == 2'b01;
  endproperty

  a_okay: assert property (p_okay) else $error("bus response not okay");
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits set");
  a_rd_hole: assert property (p_rd_hole) else $error("empty slot read not zero");
  a_lock_rd: assert property (p_lock_rd) else $error("lock bits wrong");
  a_pump_wr: assert property (p_pump_wr) else $error("pump code not written");
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("pll controls wrong");
  a_flag: assert property (p_flag) else $error("dual flag did not follow");
  a_rst: assert property (p_rst) else $error("reset values wrong");
endmodule : apd_diag_chk

// *** afe_pll_diag_control_bank_bench.sv ***
// self-checking bench for the diagnostic control bank
`timescale 1ns/10ps
module afe_pll_diag_control_bank_bench;
  logic        core_clk = 1'b0;
  logic        reset, hsel, hwrite, dual_flag_in, tune_compare, hreadyout, hresp;
  logic        video_pll_lock_in, aux_pll_lock_in, adc_ref_low_select, ref_level_select;
  logic        adc_clock_multiple_select, chan_one_test_route, chan_one_filter_disable;
  logic        first_adc_source_select, audio_dual_flag, video_dual_flag, aux_pll_reset;
  logic        video_pll_reset, aux_pll_fraction_disable, video_pll_fraction_disable;
  logic [1:0]  htrans, core_regulator_select, ref_buffer_bias, comparator_current;
  logic [1:0]  adc_bias_current, filter_bias_multiplier, converter_bias_multiplier;
  logic [2:0]  hsize;
  logic [4:0]  filter_tune_code;
  logic [5:0]  pll_pump_code;
  logic [31:0] haddr, hwdata, hrdata, rd;
  wire logic   hready;
  int          errors = 0;
  int          num_checks = 0;
  logic [8:0]  ix [7] = '{9'h134, 9'h135, 9'h136, 9'h13C, 9'h13F, 9'h140, 9'h141};
  logic [7:0]  wm [7] = '{8'h0F, 8'h7F, 8'h0F, 8'h0F, 8'h03, 8'h3F, 8'h0F};
  logic [7:0]  pm [7] = '{8'h0F, 8'h7F, 8'h0F, 8'h0E, 8'h00, 8'h3F, 8'h0F};
  logic [7:0]  rv [7] = '{8'h02, 8'h18, 8'h05, 8'h00, 8'h00, 8'h04, 8'h30};
  logic [7:0]  pat [4] = '{8'hFF, 8'hA5, 8'h5A, 8'h00};
  logic [31:0] ua [4] = '{32'h4DC, 32'h4F8, 32'hCD0, 32'h7FC};
  logic [31:0] ue [4] = '{32'h0, 32'h3F, 32'h0, 32'h0};

  assign hready = hreadyout;
  always #20 core_clk = ~core_clk;

  apd_diag_bank dut (.core_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .dual_flag_in, .tune_compare, .video_pll_lock_in,
    .aux_pll_lock_in, .adc_ref_low_select, .core_regulator_select, .adc_clock_multiple_select,
    .ref_buffer_bias, .comparator_current, .ref_level_select, .adc_bias_current,
    .filter_bias_multiplier, .converter_bias_multiplier, .chan_one_test_route,
    .chan_one_filter_disable, .first_adc_source_select, .filter_tune_code, .audio_dual_flag,
    .video_dual_flag, .pll_pump_code, .aux_pll_reset, .video_pll_reset,
    .aux_pll_fraction_disable, .video_pll_fraction_disable);

  function automatic logic [31:0] ad(input logic [8:0] idx);
    ad = {21'h0, idx, 2'b00};
  endfunction : ad

  function automatic logic [7:0] outs(input logic [8:0] idx);
    case (idx)
      9'h134: outs = {4'h0, adc_ref_low_select, core_regulator_select, adc_clock_multiple_select};
      9'h135: outs = {1'b0, ref_buffer_bias, comparator_current, ref_level_select, adc_bias_current};
      9'h136: outs = {4'h0, filter_bias_multiplier, converter_bias_multiplier};
      9'h13C: outs = {4'h0, chan_one_test_route, chan_one_filter_disable,
        first_adc_source_select, 1'b0};
      9'h140: outs = {2'b00, pll_pump_code};
      9'h141: outs = {4'h0, aux_pll_reset, video_pll_reset, aux_pll_fraction_disable,
        video_pll_fraction_disable};
      default: outs = 8'h00;
    endcase
  endfunction : outs

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // ready is looked at half a cycle ahead, so the value used is the one the edge samples
  task automatic wait_rdy(output logic [31:0] d);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    d = hrdata;
    @(posedge core_clk);
  endtask : wait_rdy

  task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    @(posedge core_clk);
    haddr  <= a;
    hwrite <= 1'b1;
    htrans <= 2'b10;
    wait_rdy(x);
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy(x);
  endtask : bus_wr

  task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
    logic [31:0] x;
    @(posedge core_clk);
    haddr  <= a;
    hwrite <= 1'b0;
    htrans <= 2'b10;
    wait_rdy(x);
    htrans <= 2'b00;
    wait_rdy(d);
  endtask : bus_rd

  task automatic final_report;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report

  initial begin
    #800000;
    errors++;
    final_report();
  end

  initial begin
    {hwrite, haddr, hwdata, htrans, dual_flag_in} = '0;
    {hsel, video_pll_lock_in, aux_pll_lock_in, tune_compare} = 4'hF;
    hsize = 3'h2;
    reset = 1'b1;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    foreach (ix[i]) begin
      bus_rd(ad(ix[i]), rd);
      chk(rd, {24'h0, rv[i]});
      chk(outs(ix[i]), {24'h0, rv[i] & pm[i]});
    end
    bus_rd(ad(9'h13E), rd);
    chk(rd, 32'h3F);
    foreach (pat[p]) foreach (ix[i]) begin
      bus_wr(ad(ix[i]), {24'hFFFFFF, pat[p]});
      bus_rd(ad(ix[i]), rd);
      chk(rd, {24'h0, pat[p] & wm[i] | (i == 6 ? 8'h30 : 8'h00)});
      chk(outs(ix[i]), {24'h0, pat[p] & pm[i]});
    end // outputs above also
    for (int p = 0; p < 4; p++) begin
      bus_wr(ad(9'h13F), 32'(p));
      for (int d = 0; d < 2; d++) begin
        @(posedge core_clk);
        dual_flag_in <= d[0];
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk({audio_dual_flag, video_dual_flag}, {d[0] ^ p[1], d[0] ^ p[0]});
      end
    end
    // a low comparator clears every trial bit, so the result differs from the boot tune
    @(posedge core_clk);
    tune_compare <= 1'b0;
    bus_wr(ad(9'h13C), 32'h1);
    bus_rd(ad(9'h13E), rd);
    chk(rd, 32'h0);
    bus_wr(ad(9'h13C), 32'h0);
    repeat (8) @(posedge core_clk);
    bus_rd(ad(9'h13E), rd);
    chk(rd, 32'h20);
    bus_wr(ad(9'h13D), 32'h8A);
    tune_compare <= 1'b1;
    bus_wr(ad(9'h13C), 32'h1);
    bus_wr(ad(9'h13C), 32'h0);
    repeat (8) @(posedge core_clk);
    bus_rd(ad(9'h13E), rd);
    chk(rd, 32'h3F);
    chk(filter_tune_code, 32'h0A);
    bus_wr(ad(9'h13D), 32'h0A);
    // the applied code is registered once more after the override bit drops
    repeat (2) @(negedge core_clk);
    chk(filter_tune_code, 32'h1F);
    foreach (ua[i]) bus_wr(ua[i], 32'hFF);
    foreach (ua[i]) begin
      bus_rd(ua[i], rd);
      chk(rd, ue[i]);
    end
    bus_rd(ad(9'h134), rd);
    chk(rd, 32'h0);
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk);
      {video_pll_lock_in, aux_pll_lock_in} <= k ? 2'b10 : 2'b01;
      repeat (4) @(posedge core_clk);
      bus_rd(ad(9'h141), rd);
      chk(rd, k ? 32'h60 : 32'h90);
      bus_rd(ad(9'h141), rd);
      chk(rd, k ? 32'h20 : 32'h10);
    end
    final_report();
  end
endmodule : afe_pll_diag_control_bank_bench

bind apd_diag_bank apd_diag_chk chk_i (.core_clk, .reset, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hreadyout, .hresp, .hrdata, .dual_flag_in, .video_pll_lock_in,
  .aux_pll_lock_in, .core_regulator_select, .audio_dual_flag, .video_dual_flag, .pll_pump_code,
  .aux_pll_reset, .video_pll_reset, .aux_pll_fraction_disable, .video_pll_fraction_disable);
